//--- src/rsd_edge_detect.sv
`timescale 1ns/1ps
module rsd_edge_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic mon_pin,
  input wire rsd_pkg::rsd_edge_cfg_t edge_cfg,
  output logic level_q,
  output logic edge_hit_q
);
  import rsd_pkg::*;

  logic [2:0] sync_q;
  logic stable_q;
  logic agree;
  logic changed;

  //////////////////////////////////////////////////////////////////////////
  // three stages; only stages two and three are compared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], mon_pin};
    end
  end

  assign agree = (sync_q[1] == sync_q[2]);
  assign changed = agree && (sync_q[2] != stable_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stable_q <= 1'b0;
    end else if (changed) begin
      stable_q <= sync_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // polarity gating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_hit_q <= 1'b0;
    end else begin
      edge_hit_q <= changed && ((sync_q[2] && edge_cfg.pos_en) ||
                                (!sync_q[2] && edge_cfg.neg_en));
    end
  end

  assign level_q = stable_q;

endmodule

//--- src/rsd_pin_mux.sv
`timescale 1ns/1ps
module rsd_pin_mux (
  input wire logic clk,
  input wire logic rst,
  input wire rsd_pkg::rsd_pin_cfg_t pin_cfg,
  input wire logic suspend_state,
  input wire logic rx_activity,
  output logic pin_o_q,
  output logic pin_oe_q
);
  import rsd_pkg::*;

  logic out_d;
  logic oe_d;

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    out_d = 1'b0;
    oe_d = 1'b0;
    case (pin_cfg.designation)
      // direction honoured only for general-purpose use
      RSD_DES_GPIO: begin
        oe_d = !pin_cfg.dir_in;
        out_d = pin_cfg.out_val;
      end
      RSD_DES_SUSPEND: begin
        oe_d = 1'b1;
        out_d = suspend_state;
      end
      RSD_DES_RX_LED: begin
        oe_d = 1'b1;
        out_d = rx_activity;
      end
      default: begin
        oe_d = 1'b0;
        out_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_o_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q <= out_d;
      pin_oe_q <= oe_d;
    end
  end

endmodule

//--- src/rsd_pkg.sv
package rsd_pkg;

  // register byte addresses
  localparam logic [7:0] RSD_CMD_W0_ADDR = 8'h00;
  localparam logic [7:0] RSD_CMD_W1_ADDR = 8'h04;
  localparam logic [7:0] RSD_CMD_W2_ADDR = 8'h08;
  localparam logic [7:0] RSD_EXEC_ADDR = 8'h0C;
  localparam logic [7:0] RSD_SETTINGS_ADDR = 8'h10;
  localparam logic [7:0] RSD_IRQ_STAT_ADDR = 8'h14;
  localparam logic [7:0] RSD_IRQ_MASK_ADDR = 8'h18;
  localparam int RSD_ADDR_W = 8;

  // command layout
  localparam logic [7:0] RSD_CMD_CODE = 8'h60;
  localparam int RSD_BYTE_CODE = 0;
  localparam int RSD_BYTE_ADC = 5;
  localparam int RSD_BYTE_EDGE = 6;
  localparam int RSD_BYTE_ALTER = 7;
  localparam int RSD_BYTE_PIN0 = 8;
  localparam int RSD_LOAD_BIT = 7;
  localparam int RSD_ADC_SRC_BIT = 0;
  localparam int RSD_ADC_LVL_LSB = 1;
  localparam int RSD_POS_MOD_BIT = 4;
  localparam int RSD_POS_VAL_BIT = 3;
  localparam int RSD_NEG_MOD_BIT = 2;
  localparam int RSD_NEG_VAL_BIT = 1;
  localparam int RSD_FLAG_CLR_BIT = 0;
  localparam int RSD_PIN_OUT_BIT = 4;
  localparam int RSD_PIN_DIR_BIT = 3;
  localparam int RSD_PIN_DES_LSB = 0;
  localparam int RSD_EXEC_GO_BIT = 0;

  // interrupt status bits
  localparam int RSD_IRQ_APPLIED = 0;
  localparam int RSD_IRQ_REJECTED = 1;
  localparam int RSD_IRQ_EDGE = 2;
  localparam int RSD_IRQ_W = 3;

  typedef enum logic [1:0] {
    RSD_VRM_OFF = 2'h0,
    RSD_VRM_LOW = 2'h1,
    RSD_VRM_MID = 2'h2,
    RSD_VRM_HIGH = 2'h3
  } rsd_vrm_level_t;

  typedef enum logic [2:0] {
    RSD_DES_GPIO = 3'h0,
    RSD_DES_SUSPEND = 3'h1,
    RSD_DES_RX_LED = 3'h2
  } rsd_designation_t;

  typedef struct packed {
    rsd_vrm_level_t vrm_level;
    logic use_vrm;
  } rsd_adc_ref_t;

  typedef struct packed {
    logic out_val;
    logic dir_in;
    rsd_designation_t designation;
  } rsd_pin_cfg_t;

  typedef struct packed {
    logic pos_en;
    logic neg_en;
  } rsd_edge_cfg_t;

  // power-up defaults, restored by every reset
  localparam rsd_adc_ref_t RSD_ADC_RESET = '{vrm_level: RSD_VRM_OFF, use_vrm: 1'b0};
  localparam rsd_pin_cfg_t RSD_PIN_RESET = '{out_val: 1'b0, dir_in: 1'b1,
                                              designation: RSD_DES_GPIO};
  localparam rsd_edge_cfg_t RSD_EDGE_RESET = '{pos_en: 1'b0, neg_en: 1'b0};
  localparam logic [31:0] RSD_WORD_RESET = 32'h0000_0000;
  localparam logic [RSD_IRQ_W-1:0] RSD_IRQ_RESET = 3'h0;

endpackage

//--- src/rsd_settings_decoder.sv
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module rsd_settings_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mon_pin,
  input wire logic suspend_state,
  input wire logic rx_activity,
  input wire logic first_general_pin_i,
  output logic first_general_pin_o,
  output logic first_general_pin_oe,
  output rsd_pkg::rsd_adc_ref_t adc_ref,
  output logic detect_flag,
  output logic irq
);
  import rsd_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // command bytes in three little-endian words
  logic [31:0] cmd_w0_q;
  logic [31:0] cmd_w1_q;
  logic [31:0] cmd_w2_q;

  function automatic logic [7:0] cmd_byte(input logic [31:0] w0, input logic [31:0] w1,
                                          input logic [31:0] w2, input int idx);
    logic [95:0] all;
    all = {w2, w1, w0};
    return all[idx*8 +: 8];
  endfunction

  logic [7:0] b_code;
  logic [7:0] b_adc;
  logic [7:0] b_edge;
  logic [7:0] b_alter;
  logic [7:0] b_pin;

  assign b_code = cmd_byte(cmd_w0_q, cmd_w1_q, cmd_w2_q, RSD_BYTE_CODE);
  assign b_adc = cmd_byte(cmd_w0_q, cmd_w1_q, cmd_w2_q, RSD_BYTE_ADC);
  assign b_edge = cmd_byte(cmd_w0_q, cmd_w1_q, cmd_w2_q, RSD_BYTE_EDGE);
  assign b_alter = cmd_byte(cmd_w0_q, cmd_w1_q, cmd_w2_q, RSD_BYTE_ALTER);
  assign b_pin = cmd_byte(cmd_w0_q, cmd_w1_q, cmd_w2_q, RSD_BYTE_PIN0);

  //////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  logic ph_valid_q;
  logic ph_write_q;
  logic [RSD_ADDR_W-1:0] ph_addr_q;
  logic addr_take;
  logic [RSD_ADDR_W-1:0] a_addr;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;

  assign addr_take = hsel && htrans[1] && hready;
  assign a_addr = haddr[RSD_ADDR_W-1:0];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q <= 8'h00;
    end else if (hready) begin
      ph_valid_q <= addr_take;
      ph_write_q <= hwrite;
      ph_addr_q <= a_addr;
    end
  end

  // zero wait states: ready only drops while in reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout_q <= 1'b0;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  // no error responses exist; registered so the output comes from a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hresp_q <= 1'b0;
    end else begin
      hresp_q <= 1'b0;
    end
  end

  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign hrdata = hrdata_q;

  logic wr_en;
  assign wr_en = ph_valid_q && ph_write_q;

  //////////////////////////////////////////////////////////////////////////
  // command buffer writes
  // words may come in any order; nothing acts before the execute write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_w0_q <= RSD_WORD_RESET;
      cmd_w1_q <= RSD_WORD_RESET;
      cmd_w2_q <= RSD_WORD_RESET;
    end else if (wr_en) begin
      if (ph_addr_q == RSD_CMD_W0_ADDR) begin
        cmd_w0_q <= hwdata;
      end else if (ph_addr_q == RSD_CMD_W1_ADDR) begin
        cmd_w1_q <= hwdata;
      end else if (ph_addr_q == RSD_CMD_W2_ADDR) begin
        cmd_w2_q <= hwdata;
      end
    end
  end

  // execute pulse: the command applies the cycle after the write's data phase
  logic exec_q;
  logic exec_d;
  assign exec_d = wr_en && (ph_addr_q == RSD_EXEC_ADDR) && hwdata[RSD_EXEC_GO_BIT];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      exec_q <= 1'b0;
    end else begin
      exec_q <= exec_d;
    end
  end

  logic apply;
  logic reject;
  assign apply = exec_q && (b_code == RSD_CMD_CODE);
  // a wrong code drops every field, not only byte zero
  assign reject = exec_q && (b_code != RSD_CMD_CODE);

  //////////////////////////////////////////////////////////////////////////
  // volatile settings, defaults on every reset
  rsd_adc_ref_t adc_q;
  rsd_edge_cfg_t edge_q;
  rsd_pin_cfg_t pin_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_q <= RSD_ADC_RESET;
    end else if (apply && b_adc[RSD_LOAD_BIT]) begin
      adc_q.vrm_level <= rsd_vrm_level_t'(b_adc[RSD_ADC_LVL_LSB +: 2]);
      adc_q.use_vrm <= b_adc[RSD_ADC_SRC_BIT];
    end
  end

  logic edge_mod;
  assign edge_mod = apply && b_edge[RSD_LOAD_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_q <= RSD_EDGE_RESET;
    end else if (edge_mod) begin
      if (b_edge[RSD_POS_MOD_BIT]) begin
        edge_q.pos_en <= b_edge[RSD_POS_VAL_BIT];
      end
      if (b_edge[RSD_NEG_MOD_BIT]) begin
        edge_q.neg_en <= b_edge[RSD_NEG_VAL_BIT];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= RSD_PIN_RESET;
    end else if (apply && b_alter[RSD_LOAD_BIT]) begin
      pin_q.out_val <= b_pin[RSD_PIN_OUT_BIT];
      pin_q.dir_in <= b_pin[RSD_PIN_DIR_BIT];
      // unlisted codes keep the old designation
      if (b_pin[RSD_PIN_DES_LSB +: 3] <= 3'(RSD_DES_RX_LED)) begin
        pin_q.designation <= rsd_designation_t'(b_pin[RSD_PIN_DES_LSB +: 3]);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // edge detection and flag
  logic mon_level;
  logic edge_hit;

  rsd_edge_detect u_edge (
    .clk(clk),
    .rst(rst),
    .mon_pin(mon_pin),
    .edge_cfg(edge_q),
    .level_q(mon_level),
    .edge_hit_q(edge_hit)
  );

  logic flag_q;
  // a new edge wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else if (edge_hit) begin
      flag_q <= 1'b1;
    end else if (edge_mod && b_edge[RSD_FLAG_CLR_BIT]) begin
      flag_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pin driver
  // pin drive per designation
  rsd_pin_mux u_pin (
    .clk(clk),
    .rst(rst),
    .pin_cfg(pin_q),
    .suspend_state(suspend_state),
    .rx_activity(rx_activity),
    .pin_o_q(first_general_pin_o),
    .pin_oe_q(first_general_pin_oe)
  );

  // pin level is an async input; same three-stage treatment as the monitor
  // readback only; nothing edge-sensitive hangs on it
  logic [2:0] gp_sync_q;
  logic gp_level_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gp_sync_q <= 3'h0;
    end else begin
      gp_sync_q <= {gp_sync_q[1:0], first_general_pin_i};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gp_level_q <= 1'b0;
    end else if (gp_sync_q[1] == gp_sync_q[2]) begin
      gp_level_q <= gp_sync_q[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status, mask, output
  logic [RSD_IRQ_W-1:0] irq_stat_q;
  logic [RSD_IRQ_W-1:0] irq_mask_q;
  logic [RSD_IRQ_W-1:0] irq_set;
  logic stat_rd;
  logic [RSD_IRQ_W-1:0] irq_stat_d;

  assign irq_set = {edge_hit, reject, apply};
  // read-clear happens at the address phase so the read returns the old value
  assign stat_rd = addr_take && !hwrite && (a_addr == RSD_IRQ_STAT_ADDR);
  // set wins over the read-clear, so an event in the read cycle survives
  assign irq_stat_d = (irq_stat_q & ~{RSD_IRQ_W{stat_rd}}) | irq_set;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= RSD_IRQ_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_mask_q <= RSD_IRQ_RESET;
    end else if (wr_en && ph_addr_q == RSD_IRQ_MASK_ADDR) begin
      irq_mask_q <= hwdata[RSD_IRQ_W-1:0];
    end
  end

  logic irq_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, registered during the address phase
  logic [31:0] settings_word;
  assign settings_word = {16'h0000, 3'h0, gp_level_q, mon_level, flag_q,
                          edge_q, pin_q, adc_q};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_take && !hwrite) begin
      if (a_addr == RSD_CMD_W0_ADDR) begin
        hrdata_q <= cmd_w0_q;
      end else if (a_addr == RSD_CMD_W1_ADDR) begin
        hrdata_q <= cmd_w1_q;
      end else if (a_addr == RSD_CMD_W2_ADDR) begin
        hrdata_q <= cmd_w2_q;
      end else if (a_addr == RSD_SETTINGS_ADDR) begin
        hrdata_q <= settings_word;
      end else if (a_addr == RSD_IRQ_STAT_ADDR) begin
        hrdata_q <= {29'h0, irq_stat_q};
      end else if (a_addr == RSD_IRQ_MASK_ADDR) begin
        hrdata_q <= {29'h0, irq_mask_q};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // settings as outputs
  assign adc_ref = adc_q;
  assign detect_flag = flag_q;
  assign irq = irq_q;

endmodule

//--- verif/rsd_chk.sv
`timescale 1ns/1ps
module rsd_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic mon_pin,
  input wire logic first_general_pin_oe,
  input wire rsd_pkg::rsd_adc_ref_t adc_ref,
  input wire logic detect_flag,
  input wire logic irq
);
  import rsd_pkg::*;
  logic acc;
  logic ex;
  logic mk;
  logic rd;
  logic pin_q;
  logic [3:0] since_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign acc = hsel & htrans[1] & hready;
  assign ex = acc & hwrite & (haddr[7:0] == RSD_EXEC_ADDR);
  assign mk = acc & hwrite & (haddr[7:0] == RSD_IRQ_MASK_ADDR);
  assign rd = acc & !hwrite;
  // cycles since the monitored pin last moved, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 1'b0;
      since_q <= 4'hF;
    end else begin
      pin_q <= mon_pin;
      since_q <= (mon_pin != pin_q) ? 4'h0 : (since_q == 4'hF ? since_q : since_q + 4'h1);
    end
  end
  ////////////////////////////////////////////////////////////////
  property p_adc_hold;
    $changed(adc_ref) |-> $past(ex, 3);
  endproperty
  a_adc_hold: assert property (p_adc_hold) else $error("adc_ref moved without command");
  property p_oe_hold;
    $changed(first_general_pin_oe) |-> $past(ex, 4);
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("pin enable moved alone");
  property p_flag_clear;
    $fell(detect_flag) |-> $past(ex, 3);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag fell without command");
  property p_flag_rise;
    $rose(detect_flag) |-> since_q <= 4'hC;
  endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag rose without pin edge");
  property p_irq_rise;
    $rose(irq) |-> $past(ex, 3) || $past(mk, 3) || detect_flag;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_rdata_hold;
    $changed(hrdata) |-> $past(rd);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved unasked");
  property p_ready;
    !$past(rst) |-> hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("bus stalled");
  property p_resp;
    hresp == 1'b0;
  endproperty
  a_resp: assert property (p_resp) else $error("bus response not okay");
endmodule

bind rsd_settings_decoder rsd_chk u_chk (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .mon_pin(mon_pin), .first_general_pin_oe(first_general_pin_oe),
  .adc_ref(adc_ref), .detect_flag(detect_flag), .irq(irq));

//--- verif/rsd_host_model.sv
`timescale 1ns/1ps
module rsd_host_model (
  input wire logic clk,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  import rsd_pkg::*;
  initial begin
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // single word transfer, waits on ready in both phases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    if (w) hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [31:0] w1, input logic [7:0] b8);
    logic [31:0] r;
    xfer(1'b1, RSD_CMD_W0_ADDR, {24'h0, code}, r);
    xfer(1'b1, RSD_CMD_W1_ADDR, w1, r);
    xfer(1'b1, RSD_CMD_W2_ADDR, {24'h0, b8}, r);
    xfer(1'b1, RSD_EXEC_ADDR, 32'h1, r);
    repeat (3) @(posedge clk);
  endtask
endmodule

//--- verif/runtime_settings_command_decoder_tb_top.sv
`timescale 1ns/1ps
module runtime_settings_command_decoder_tb_top;
  import rsd_pkg::*;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, mon_pin, susp, rxa;
  logic pin_i, pin_o, pin_oe, flag, irq, a;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rsd_adc_ref_t adc;
  int err_total, checked;
  rsd_settings_decoder dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .mon_pin(mon_pin),
    .suspend_state(susp), .rx_activity(rxa), .first_general_pin_i(pin_i),
    .first_general_pin_o(pin_o), .first_general_pin_oe(pin_oe), .adc_ref(adc),
    .detect_flag(flag), .irq(irq));
  rsd_host_model u_host (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  // undriven pin rests high on its pull-up
  assign pin_i = pin_oe ? pin_o : 1'b1;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] ad);
    u_host.xfer(1'b0, ad, 32'h0, r);
  endtask
  task automatic ec(input logic [7:0] b6, input logic e);
    u_host.cmd(RSD_CMD_CODE, {8'h0, b6, 16'h0}, 8'h0);
    chk("flag_cmd", {31'h0, e}, {31'h0, flag});
  endtask
  task automatic tog(input logic v, input logic e);
    mon_pin <= v;
    repeat (10) @(posedge clk);
    chk("flag_edge", {31'h0, e}, {31'h0, flag});
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    err_total++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    mon_pin = 1'b0;
    susp = 1'b0;
    rxa = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(RSD_SETTINGS_ADDR);
    chk("settings", 32'h040, r & 32'h7FF);
    rd(8'h1C);
    chk("unmapped", 32'h0, r);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      u_host.cmd(RSD_CMD_CODE, {16'h0, 8'hF8 | 8'(i), 8'h0}, 8'h0);
      chk("adc_ref", i, {29'h0, adc});
    end
    u_host.cmd(RSD_CMD_CODE, 32'h0000_7200, 8'h0);
    chk("adc_keep", 32'h7, {29'h0, adc});
    $display("test adc done");
    u_host.cmd(RSD_CMD_CODE, 32'h8000_0000, 8'hF0);
    chk("pin_o", 32'h1, {31'h0, pin_o});
    chk("pin_oe", 32'h1, {31'h0, pin_oe});
    u_host.cmd(RSD_CMD_CODE, 32'h0, 8'h18);
    chk("pin_oe_keep", 32'h1, {31'h0, pin_oe});
    for (int j = 1; j < 3; j++) begin
      u_host.cmd(RSD_CMD_CODE, 32'h8000_0000, 8'(j));
      for (int v = 0; v < 2; v++) begin
        susp <= (j == 1) ? v[0] : ~v[0];
        rxa <= (j == 2) ? v[0] : ~v[0];
        repeat (3) @(posedge clk);
        chk("pin_alt", v, {31'h0, pin_o});
      end
    end
    u_host.cmd(RSD_CMD_CODE, 32'h8000_0000, 8'h0B);
    rd(RSD_SETTINGS_ADDR);
    chk("des_keep", 32'h2, (r >> 3) & 32'h7);
    u_host.cmd(RSD_CMD_CODE, 32'h8000_0000, 8'h18);
    chk("pin_oe_in", 32'h0, {31'h0, pin_oe});
    $display("test pin done");
    ec(8'h98, 1'b0);
    tog(1'b1, 1'b1);
    ec(8'h81, 1'b0);
    tog(1'b0, 1'b0);
    ec(8'h86, 1'b0);
    tog(1'b1, 1'b1);
    ec(8'h19, 1'b1);
    ec(8'h91, 1'b0);
    tog(1'b0, 1'b1);
    ec(8'h81, 1'b0);
    tog(1'b1, 1'b0);
    $display("test edge done");
    rd(RSD_IRQ_STAT_ADDR);
    u_host.xfer(1'b1, RSD_IRQ_MASK_ADDR, 32'h0, r);
    u_host.cmd(8'h61, 32'h0000_8100, 8'h0);
    chk("adc_bad_code", 32'h7, {29'h0, adc});
    a = irq;
    u_host.xfer(1'b1, RSD_IRQ_MASK_ADDR, 32'h7, r);
    repeat (2) @(posedge clk);
    chk("irq_mask_flip", 32'h1, {31'h0, irq ^ a});
    rd(RSD_IRQ_MASK_ADDR);
    chk("mask", 32'h7, r);
    rd(RSD_IRQ_STAT_ADDR);
    chk("stat_reject", 32'h2, r);
    rd(RSD_IRQ_STAT_ADDR);
    chk("stat_clear", 32'h0, r);
    chk("irq_clear", 32'h0, {31'h0, irq});
    u_host.cmd(RSD_CMD_CODE, 32'h0, 8'h0);
    rd(RSD_IRQ_STAT_ADDR);
    chk("stat_apply", 32'h1, r);
    $display("test irq done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("adc_reset", 32'h0, {29'h0, adc});
    rd(RSD_SETTINGS_ADDR);
    chk("settings_reset", 32'h040, r & 32'h7FF);
    $display("test volatile done");
    wrap_up();
  end
endmodule
